// ===== hw/alr_pkg.sv
// shared constants, register map and types for the amplitude and role resolver
package alr_pkg;

   // ************************************************************
   // register map (byte addresses on the 32-bit bus)
   // ************************************************************
   localparam int unsigned ADDR_W      = 5;
   localparam logic [4:0]  REG_CTRL    = 5'h00;
   localparam logic [4:0]  REG_ADV     = 5'h04;
   localparam logic [4:0]  REG_PARTNER = 5'h08;
   localparam logic [4:0]  REG_STATUS  = 5'h0c;

   // control bits, write one to act, read as zero
   localparam int unsigned CTRL_RESTART  = 0;
   localparam int unsigned CTRL_SOFT_RST = 1;

   // status layout
   localparam int unsigned ST_DONE     = 0;
   localparam int unsigned ST_HI_AMP   = 1;
   localparam int unsigned ST_ROLE_LO  = 2;
   localparam int unsigned ST_LINK_EN  = 4;
   localparam int unsigned ST_STRAP_HI = 5;

   // role resolution codes
   localparam logic [1:0] ROLE_NONE   = 2'h0;
   localparam logic [1:0] ROLE_MASTER = 2'h1;
   localparam logic [1:0] ROLE_SLAVE  = 2'h2;
   localparam logic [1:0] ROLE_FAULT  = 2'h3;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // timing and reset values
   // ************************************************************
   localparam logic [1:0]  STRAP_SETTLE = 2'h3;  // edges until the synced straps load the strap defaults
   localparam logic [15:0] LFSR_SEED    = 16'hace1;
   localparam logic [15:0] LFSR_TAPS    = 16'hb400;

   // one page worth of advertisement bits, local or partner
   typedef struct packed {
      logic role_forced;
      logic master_pref;
      logic hi_request;
      logic hi_ability;
   } alr_adv_t;

   localparam int unsigned ADV_W = 4;

   typedef enum logic [1:0] {
      AN_RUN,
      AN_DONE,
      AN_FAIL
   } alr_an_state_t;

endpackage : alr_pkg

// ===== hw/alr_lfsr.sv
// free running lfsr giving the random bit for role tie breaks
`timescale 1ns/1ps
module alr_lfsr #(
   parameter int unsigned W = 16
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // random bit, registered
   output logic      rnd_bit
);

   logic [W-1:0] lfsr_q;
   logic [W-1:0] lfsr_d;

   // galois step; seed is never zero so it cannot lock up
   always_comb begin
      lfsr_d = {1'b0, lfsr_q[W-1:1]};
      if (lfsr_q[0]) begin
         lfsr_d = lfsr_d ^ alr_pkg::LFSR_TAPS[W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lfsr_q <= alr_pkg::LFSR_SEED[W-1:0];
      end else begin
         lfsr_q <= lfsr_d;
      end
   end

   assign rnd_bit = lfsr_q[0];

endmodule : alr_lfsr

// ===== hw/alr_resolver.sv
// transmit amplitude and master/slave resolution with axi4-lite registers
// Notes on behaviour
// - high level request needs the strap
// - capture partner level bits, valid when done
// - low amplitude if ability missing or no request
// - high amplitude: both able, one requests
// - resolve amplitude only when strapped high
// - software writes level bits only when strapped
// - local ability cleared forces low amplitude
// - master preference loads from strap, software overrides
// - forced bit makes preference a mandatory role
// - same forced roles give fault, negotiation fails
// - capture partner role bits, valid when done
// - equal preferences resolved by random choice
// - single forced side gets its role
// - differing roles kept as advertised
// - role result field: master, slave, fault
// - floating role strap means slave preference
// - restart on link drop or software
// - failed negotiation keeps link down
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module alr_resolver (
   // clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // strap pins, asynchronous
   input  wire logic                        high_amplitude_strap,
   input  wire logic                        role_pref_strap,
   // page exchange engine and pcs, same clock
   input  wire logic                        pg_partner_valid,
   input  wire alr_pkg::alr_adv_t           pg_partner_adv,
   input  wire logic                        pg_exchange_done,
   input  wire logic                        link_up,
   output alr_pkg::alr_adv_t                local_adv_q,
   output logic                             negotiation_restart_q,
   // resolved operating point
   output logic                             hi_amplitude_q,
   output logic                             role_master_q,
   output logic                             link_enable_q,
   // axi4-lite write
   input  wire logic [alr_pkg::ADDR_W-1:0]  s_awaddr,
   input  wire logic                        s_awvalid,
   output logic                             s_awready,
   input  wire logic [31:0]                 s_wdata,
   input  wire logic [3:0]                  s_wstrb,
   input  wire logic                        s_wvalid,
   output logic                             s_wready,
   output logic [1:0]                       s_bresp,
   output logic                             s_bvalid,
   input  wire logic                        s_bready,
   // axi4-lite read
   input  wire logic [alr_pkg::ADDR_W-1:0]  s_araddr,
   input  wire logic                        s_arvalid,
   output logic                             s_arready,
   output logic [31:0]                      s_rdata,
   output logic [1:0]                       s_rresp,
   output logic                             s_rvalid,
   input  wire logic                        s_rready
);

   // ************************************************************
   // functions
   // ************************************************************
   function automatic logic amp_resolve(input logic strap_hi, input alr_pkg::alr_adv_t l,
                                        input alr_pkg::alr_adv_t p);
      amp_resolve = strap_hi & l.hi_ability & p.hi_ability & (l.hi_request | p.hi_request);
   endfunction : amp_resolve

   function automatic logic [1:0] role_resolve(input alr_pkg::alr_adv_t l,
                                               input alr_pkg::alr_adv_t p, input logic rnd);
      logic master;
      master = l.master_pref;
      // forced bits turn preferences into roles
      if (l.role_forced && p.role_forced && (l.master_pref == p.master_pref)) begin
         return alr_pkg::ROLE_FAULT;
      end
      // lone forced side keeps its role
      if (!l.role_forced && p.role_forced) begin
         master = ~p.master_pref;
      end else if (!l.role_forced && (l.master_pref == p.master_pref)) begin
         master = rnd;
      end
      role_resolve = master ? alr_pkg::ROLE_MASTER : alr_pkg::ROLE_SLAVE;
   endfunction : role_resolve

   // ************************************************************
   // strap synchronisers
   // ************************************************************
   logic [1:0] amp_sync_q;
   logic [1:0] role_sync_q;
   logic       strap_hi;
   logic       strap_master;

   // two stages; only the second stage feeds logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         amp_sync_q  <= 2'h0;
         role_sync_q <= 2'h0;
      end else begin
         amp_sync_q  <= {amp_sync_q[0], high_amplitude_strap};
         role_sync_q <= {role_sync_q[0], role_pref_strap};
      end
   end

   assign strap_hi     = amp_sync_q[1];
   assign strap_master = role_sync_q[1];

   logic rnd_bit;

   alr_lfsr #(.W(16)) u_lfsr (
      .aclk    (aclk),
      .aresetn (aresetn),
      .rnd_bit (rnd_bit)
   );

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   logic [alr_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
   logic                       aw_have_q, aw_have_d;
   logic [7:0]                 wbyte_q, wbyte_d;
   logic                       wlane_q, wlane_d;
   logic                       w_have_q, w_have_d;
   logic                       bvalid_d;
   logic [1:0]                 bresp_d;
   logic                       rvalid_d;
   logic [1:0]                 rresp_d;
   logic [31:0]                rdata_d;
   logic                       wr_fire;
   logic [31:0]                status_word;
   alr_pkg::alr_adv_t          partner_q, partner_d;

   // address and data may come in either order; one write at a time
   always_comb begin
      aw_have_d = aw_have_q;
      awaddr_d  = awaddr_q;
      w_have_d  = w_have_q;
      wbyte_d   = wbyte_q;
      wlane_d   = wlane_q;
      bvalid_d  = s_bvalid;
      bresp_d   = s_bresp;
      wr_fire   = 1'b0;
      if (s_awvalid && s_awready) begin
         aw_have_d = 1'b1;
         awaddr_d  = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         w_have_d = 1'b1;
         wbyte_d  = s_wdata[7:0];
         wlane_d  = s_wstrb[0];
      end
      if (s_bvalid && s_bready) begin
         bvalid_d = 1'b0;
      end
      if (aw_have_q && w_have_q && !s_bvalid) begin
         wr_fire   = 1'b1;
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = (awaddr_q == alr_pkg::REG_CTRL || awaddr_q == alr_pkg::REG_ADV)
                     ? alr_pkg::RESP_OKAY : alr_pkg::RESP_SLVERR;
      end
   end

   // read answers one cycle after the address is taken
   always_comb begin
      rvalid_d = s_rvalid;
      rresp_d  = s_rresp;
      rdata_d  = s_rdata;
      if (s_rvalid && s_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = alr_pkg::RESP_OKAY;
         unique case (s_araddr)
            alr_pkg::REG_CTRL:    rdata_d = 32'h0;
            alr_pkg::REG_ADV:     rdata_d = {28'h0, local_adv_q};
            alr_pkg::REG_PARTNER: rdata_d = {28'h0, partner_q};
            alr_pkg::REG_STATUS:  rdata_d = status_word;
            default: begin
               rdata_d = 32'h0;
               rresp_d = alr_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   // ready flags registered from the next holding state, so every output is a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         s_awready <= 1'b1;
         s_wready  <= 1'b1;
         s_arready <= 1'b1;
         awaddr_q  <= '0;
         w_have_q  <= 1'b0;
         wbyte_q   <= 8'h0;
         wlane_q   <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= alr_pkg::RESP_OKAY;
         s_rvalid  <= 1'b0;
         s_rresp   <= alr_pkg::RESP_OKAY;
         s_rdata   <= 32'h0;
      end else begin
         aw_have_q <= aw_have_d;
         s_awready <= !aw_have_d;
         s_wready  <= !w_have_d;
         s_arready <= !rvalid_d;
         awaddr_q  <= awaddr_d;
         w_have_q  <= w_have_d;
         wbyte_q   <= wbyte_d;
         wlane_q   <= wlane_d;
         s_bvalid  <= bvalid_d;
         s_bresp   <= bresp_d;
         s_rvalid  <= rvalid_d;
         s_rresp   <= rresp_d;
         s_rdata   <= rdata_d;
      end
   end

   // ************************************************************
   // negotiation control and resolution
   // ************************************************************
   alr_pkg::alr_an_state_t state_q, state_d;
   alr_pkg::alr_adv_t      local_d;
   logic [1:0]             settle_q, settle_d;
   logic [1:0]             role_q, role_d;
   logic                   done_q, done_d;
   logic                   hi_amp_d, link_en_d, restart_d, link_prev_q;
   logic                   sw_restart, sw_reset, link_drop, resolve_ev, restart_ev;

   assign sw_restart = wr_fire && wlane_q && awaddr_q == alr_pkg::REG_CTRL
                       && wbyte_q[alr_pkg::CTRL_RESTART];
   assign sw_reset   = wr_fire && wlane_q && awaddr_q == alr_pkg::REG_CTRL
                       && wbyte_q[alr_pkg::CTRL_SOFT_RST];
   assign link_drop  = link_prev_q && !link_up;
   assign resolve_ev = state_q == alr_pkg::AN_RUN && pg_exchange_done && settle_q == 2'h0;
   assign restart_ev = sw_restart || sw_reset || (state_q == alr_pkg::AN_DONE && link_drop);

   always_comb begin
      state_d   = state_q;
      local_d   = local_adv_q;
      partner_d = partner_q;
      settle_d  = (settle_q != 2'h0) ? settle_q - 2'h1 : settle_q;
      role_d    = role_q;
      done_d    = done_q;
      hi_amp_d  = hi_amplitude_q;
      link_en_d = link_enable_q;
      restart_d = 1'b0;
      if (wr_fire && wlane_q && awaddr_q == alr_pkg::REG_ADV) begin
         local_d = alr_pkg::alr_adv_t'(wbyte_q[alr_pkg::ADV_W-1:0]);
      end
      // strap low, as the pull-down leaves it, means slave
      if (settle_q == 2'h1) begin
         local_d.master_pref = strap_master;
         local_d.role_forced = 1'b0;
         local_d.hi_ability  = strap_hi;
         local_d.hi_request  = 1'b0;
      end
      // level bits cannot be set without the strap
      if (!strap_hi) begin
         local_d.hi_ability = 1'b0;
         local_d.hi_request = 1'b0;
      end
      // partner bits taken while pages arrive
      if (state_q == alr_pkg::AN_RUN && pg_partner_valid) begin
         partner_d = pg_partner_adv;
      end
      // both results computed in the done cycle, then held
      if (resolve_ev) begin
         done_d   = 1'b1;
         hi_amp_d = amp_resolve(strap_hi, local_adv_q, partner_d);
         role_d   = role_resolve(local_adv_q, partner_d, rnd_bit);
         // equal forced roles fail the negotiation
         if (role_d == alr_pkg::ROLE_FAULT) begin
            state_d   = alr_pkg::AN_FAIL;
            link_en_d = 1'b0;
         end else begin
            state_d   = alr_pkg::AN_DONE;
            link_en_d = 1'b1;
         end
      end
      // a new negotiation clears done and link enable; amplitude and role are kept
      if (restart_ev) begin
         state_d   = alr_pkg::AN_RUN;
         done_d    = 1'b0;
         link_en_d = 1'b0;
         restart_d = 1'b1;
      end
      // software reset reloads strap defaults like a power-up
      if (sw_reset) begin
         settle_d = alr_pkg::STRAP_SETTLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q        <= alr_pkg::AN_RUN;
         local_adv_q    <= '0;
         partner_q      <= '0;
         settle_q       <= alr_pkg::STRAP_SETTLE;
         role_q         <= alr_pkg::ROLE_NONE;
         done_q         <= 1'b0;
         hi_amplitude_q <= 1'b0;
         role_master_q  <= 1'b0;
         link_enable_q  <= 1'b0;
         negotiation_restart_q   <= 1'b0;
         link_prev_q    <= 1'b0;
      end else begin
         state_q        <= state_d;
         local_adv_q    <= local_d;
         partner_q      <= partner_d;
         settle_q       <= settle_d;
         role_q         <= role_d;
         done_q         <= done_d;
         hi_amplitude_q <= hi_amp_d;
         role_master_q  <= role_d == alr_pkg::ROLE_MASTER;
         link_enable_q  <= link_en_d;
         negotiation_restart_q   <= restart_d;
         link_prev_q    <= link_up;
      end
   end

   // role field and done flag for software
   always_comb begin
      status_word                         = 32'h0;
      status_word[alr_pkg::ST_DONE]       = done_q;
      status_word[alr_pkg::ST_HI_AMP]     = hi_amplitude_q;
      status_word[alr_pkg::ST_ROLE_LO+:2] = role_q;
      status_word[alr_pkg::ST_LINK_EN]    = link_enable_q;
      status_word[alr_pkg::ST_STRAP_HI]   = strap_hi;
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_amp_no_strap: assert property (@(posedge aclk) disable iff (!aresetn)
      resolve_ev && !strap_hi |=> !hi_amplitude_q) else $error("high amplitude without strap");
   chk_amp_no_abil: assert property (@(posedge aclk) disable iff (!aresetn)
      resolve_ev && !local_adv_q.hi_ability |=> !hi_amplitude_q ##1 !hi_amplitude_q)
      else $error("high amplitude with local ability clear");
   chk_amp_no_req: assert property (@(posedge aclk) disable iff (!aresetn)
      resolve_ev && !local_adv_q.hi_request && !partner_d.hi_request |=> !hi_amplitude_q)
      else $error("high amplitude without any request");
   chk_amp_high: assert property (@(posedge aclk) disable iff (!aresetn)
      resolve_ev && strap_hi && local_adv_q.hi_ability && partner_d.hi_ability
      && (local_adv_q.hi_request || partner_d.hi_request) |=> hi_amplitude_q)
      else $error("high amplitude not selected");
   chk_fault_same_force: assert property (@(posedge aclk) disable iff (!aresetn)
      resolve_ev && local_adv_q.role_forced && partner_d.role_forced
      && local_adv_q.master_pref == partner_d.master_pref
      |=> state_q == alr_pkg::AN_FAIL && role_q == alr_pkg::ROLE_FAULT)
      else $error("forced role clash not reported");
   chk_forced_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      resolve_ev && local_adv_q.role_forced && !partner_d.role_forced
      |=> role_master_q == $past(local_adv_q.master_pref))
      else $error("local forced role not kept");
   chk_fail_link_down: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == alr_pkg::AN_FAIL |-> !link_enable_q) else $error("link up after failure");
   chk_restart_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      restart_ev |=> !done_q && negotiation_restart_q) else $error("restart left done set");
   chk_hold_results: assert property (@(posedge aclk) disable iff (!aresetn)
      done_q && !restart_ev |=> $stable(hi_amplitude_q) && $stable(role_q))
      else $error("results changed while done");
   chk_adv_gated: assert property (@(posedge aclk) disable iff (!aresetn)
      !strap_hi |=> !local_adv_q.hi_request && !local_adv_q.hi_ability)
      else $error("level bits set without strap");

endmodule : alr_resolver

// ===== testbench/alr_peer_model.sv
// behavioural remote phy: page exchange pulses and link level
`timescale 1ns/1ps
module alr_peer_model (
   // clock
   input  wire logic         aclk,
   // page exchange and link toward the resolver
   output logic              pg_partner_valid,
   output alr_pkg::alr_adv_t pg_partner_adv,
   output logic              pg_exchange_done,
   output logic              link_up
);
   // idle: no pulses, link up
   initial begin
      pg_partner_valid = 1'b0;
      pg_exchange_done = 1'b0;
      pg_partner_adv   = 4'h0;
      link_up          = 1'b1;
   end

   // one page with done in the same cycle; bits go stale (inverted) after
   task automatic exchange(input alr_pkg::alr_adv_t a);
      @(posedge aclk);
      pg_partner_valid <= 1'b1;
      pg_partner_adv   <= a;
      pg_exchange_done <= 1'b1;
      @(posedge aclk);
      pg_partner_valid <= 1'b0;
      pg_exchange_done <= 1'b0;
      pg_partner_adv   <= ~a;
   endtask : exchange

   // one-cycle drop of the link level
   task automatic drop_link();
      @(posedge aclk);
      link_up <= 1'b0;
      @(posedge aclk);
      link_up <= 1'b1;
   endtask : drop_link
endmodule : alr_peer_model

// ===== testbench/alr_resolver_tb_top.sv
// self-checking bench for the amplitude and role resolver
`timescale 1ns/1ps
module alr_resolver_tb_top;
   logic              aclk = 1'b0, aresetn = 1'b0, amp_strap = 1'b1, role_strap = 1'b0;
   logic [4:0]        awaddr = 5'h0, araddr = 5'h0;
   logic [31:0]       wdata = 32'h0, rdata;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic              rready = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic              pv, pdone, lnk, restart, hi_amp, master, link_en;
   alr_pkg::alr_adv_t padv, ladv;
   int                n_fail = 0, n_compared = 0, cyc = 0;

   always #5 aclk = ~aclk;

   alr_peer_model i_peer (.aclk(aclk), .pg_partner_valid(pv), .pg_partner_adv(padv),
      .pg_exchange_done(pdone), .link_up(lnk));

   alr_resolver i_dut (.aclk(aclk), .aresetn(aresetn), .high_amplitude_strap(amp_strap),
      .role_pref_strap(role_strap), .pg_partner_valid(pv), .pg_partner_adv(padv),
      .pg_exchange_done(pdone), .link_up(lnk), .local_adv_q(ladv), .negotiation_restart_q(restart),
      .hi_amplitude_q(hi_amp), .role_master_q(master), .link_enable_q(link_en),
      .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
      .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
      .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
      .s_rready(rready));

   // ************************************************************
   // reporting and comparisons
   // ************************************************************
   task automatic final_report();
      $display("counts: compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_word

   task automatic cmp_bit(input logic g, input logic e);
      cmp_word({31'h0, g}, {31'h0, e});
   endtask : cmp_bit

   // a hang costs one mismatch and ends the run
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end

   // ************************************************************
   // axi4-lite master: hold each channel until its own handshake
   // ************************************************************
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask : bus_wr

   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask : bus_rd

   // local advertisement, software restart, one partner page, status read
   task automatic resolve(input logic [3:0] loc, input logic [3:0] par, output logic [31:0] st);
      logic [1:0] r;
      bus_wr(alr_pkg::REG_ADV, {28'h0, loc}, r);
      bus_wr(alr_pkg::REG_CTRL, 32'h1, r);
      i_peer.exchange(par);
      bus_rd(alr_pkg::REG_STATUS, st, r);
   endtask : resolve

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic test_map();
      logic [31:0] d;
      logic [1:0]  r;
      bus_rd(alr_pkg::REG_ADV, d, r);
      cmp_word(d, 32'h1);
      bus_rd(alr_pkg::REG_CTRL, d, r);
      cmp_word(d, 32'h0);
      bus_rd(5'h10, d, r);
      cmp_word({r, d[29:0]}, {alr_pkg::RESP_SLVERR, 30'h0});
      bus_wr(alr_pkg::REG_PARTNER, 32'hf, r);
      cmp_word({30'h0, r}, {30'h0, alr_pkg::RESP_SLVERR});
      role_strap <= 1'b1;
      bus_wr(alr_pkg::REG_ADV, 32'h0, r);
      bus_wr(alr_pkg::REG_CTRL, 32'h2, r);
      repeat (6) @(posedge aclk);
      bus_rd(alr_pkg::REG_ADV, d, r);
      cmp_word(d, 32'h5);
      $display("test_map done");
   endtask : test_map

   // every mix of local and partner level ability and request
   task automatic test_amp();
      logic [31:0] st, pr;
      logic [1:0]  r;
      logic        e;
      for (int i = 0; i < 16; i++) begin
         resolve({2'b00, i[1:0]}, {2'b01, i[3:2]}, st);
         e = i[0] & i[2] & (i[1] | i[3]);
         cmp_bit(st[alr_pkg::ST_HI_AMP], e);
         cmp_bit(hi_amp, e);
         bus_rd(alr_pkg::REG_PARTNER, pr, r);
         cmp_word(pr, {28'h0, 2'b01, i[3:2]});
      end
      $display("test_amp done");
   endtask : test_amp

   // every mix of forced and preferred roles on both sides
   task automatic test_role();
      logic [31:0] st;
      logic [1:0]  e;
      for (int i = 0; i < 16; i++) begin
         if (i[3] && i[1]) e = (i[2] == i[0]) ? alr_pkg::ROLE_FAULT :
                               (i[2] ? alr_pkg::ROLE_MASTER : alr_pkg::ROLE_SLAVE);
         else if (i[3]) e = i[2] ? alr_pkg::ROLE_MASTER : alr_pkg::ROLE_SLAVE;
         else if (i[1]) e = i[0] ? alr_pkg::ROLE_SLAVE : alr_pkg::ROLE_MASTER;
         else if (i[2] != i[0]) e = i[2] ? alr_pkg::ROLE_MASTER : alr_pkg::ROLE_SLAVE;
         else e = alr_pkg::ROLE_NONE;
         resolve({i[3:2], 2'b00}, {i[1:0], 2'b00}, st);
         cmp_bit(st[alr_pkg::ST_DONE], 1'b1);
         if (e == alr_pkg::ROLE_NONE) begin
            cmp_bit(st[3:2] == alr_pkg::ROLE_MASTER || st[3:2] == alr_pkg::ROLE_SLAVE, 1'b1);
            e = st[3:2];
         end
         cmp_word({30'h0, st[3:2]}, {30'h0, e});
         cmp_bit(master, e == alr_pkg::ROLE_MASTER);
         cmp_bit(link_en, e != alr_pkg::ROLE_FAULT);
         if (e == alr_pkg::ROLE_FAULT) begin
            i_peer.drop_link();
            repeat (2) @(posedge aclk);
            cmp_bit(link_en, 1'b0);
         end
      end
      $display("test_role done");
   endtask : test_role

   // link drop after success restarts and clears done
   task automatic test_drop();
      logic [31:0] st;
      logic [1:0]  r;
      resolve(4'h1, 4'h5, st);
      cmp_bit(link_en, 1'b1);
      i_peer.drop_link();
      #1;
      cmp_word({30'h0, restart, link_en}, 32'h2);
      bus_rd(alr_pkg::REG_STATUS, st, r);
      cmp_bit(st[alr_pkg::ST_DONE], 1'b0);
      $display("test_drop done");
   endtask : test_drop

   // strap low: level bits stuck at zero and low amplitude only
   task automatic test_strap();
      logic [31:0] st;
      logic [1:0]  r;
      @(posedge aclk);
      amp_strap <= 1'b0;
      repeat (4) @(posedge aclk);
      bus_wr(alr_pkg::REG_ADV, 32'h3, r);
      bus_rd(alr_pkg::REG_ADV, st, r);
      cmp_word(st, 32'h0);
      cmp_word({28'h0, ladv}, 32'h0);
      resolve(4'h3, 4'h7, st);
      cmp_bit(st[alr_pkg::ST_STRAP_HI], 1'b0);
      cmp_bit(st[alr_pkg::ST_HI_AMP] | hi_amp, 1'b0);
      amp_strap <= 1'b1;
      $display("test_strap done");
   endtask : test_strap

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      test_map();
      test_amp();
      test_role();
      test_drop();
      test_strap();
      final_report();
   end
endmodule : alr_resolver_tb_top
